// >>> hdl/eeprom_pkg.sv
// Constants and types for the two-wire serial memory target.
// Assumes a 50 MHz reference clock; the cycle counts below derive from it.
package eeprom_pkg;

    // ========================================================================
    // Timing
    localparam int CLK_PERIOD_NS         = 20;
    localparam int NOISE_TIME_NS         = 50;    // Widest pulse treated as noise
    localparam int FILTER_CYCLES         = (NOISE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] FILTER_LAST   = 2'(FILTER_CYCLES - 1);
    localparam int PROGRAM_CYCLE_TIME_US = 5000;  // Longest self-timed write, 5 ms
    localparam int PROGRAM_CYCLE_COUNT   = PROGRAM_CYCLE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int PROG_CNT_W            = 18;

    // ========================================================================
    // Array and protocol
    localparam int ARRAY_BYTES           = 256;
    localparam int PAGE_BYTES            = 8;
    localparam logic [3:0] DEV_TYPE_CODE = 4'hA;  // Fixed one-zero-one-zero prefix
    localparam logic [3:0] BIT_LAST      = 4'h8;  // Bit count after a full byte
    localparam logic [7:0] ADDR_RESET    = 8'h00;
    localparam logic [5:0] PIN_RESET     = 6'h30; // Clock and data idle high

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_PROG} state_t;
    typedef enum logic [1:0] {PH_DEV, PH_WADDR, PH_DATA} phase_t;

    // Upper half of the array is locked while write protect is high
    function automatic logic is_protected(input logic [7:0] addr, input logic wp);
        return wp & addr[7];
    endfunction : is_protected

endpackage : eeprom_pkg

// >>> hdl/byte_fifo2.sv
// Small synchronous FIFO used as the read-data prefetch buffer.
// Assumes one clock, power-of-two depth, and a synchronous clear.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             clear,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] slot [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // ========================================================================
    // Status and read port
    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = slot[rd_ptr];

    // Pointers and occupancy
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop)  rd_ptr <= rd_ptr + 1'b1;
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Storage
    always_ff @(posedge clk) begin
        if (push && !clear) slot[wr_ptr] <= in_data;
    end

endmodule : byte_fifo2
`default_nettype wire

// >>> hdl/two_wire_eeprom_target.sv
// Two-wire serial target with a 256 x 8 array, 8-byte pages, write protect.
// Assumes pins arrive asynchronously; the data pin is open drain outside.
`timescale 1ns/1ps
`default_nettype none
module two_wire_eeprom_target
    import eeprom_pkg::*;
#(
    parameter int PROGRAM_CYCLES = PROGRAM_CYCLE_COUNT
) (
    input  wire logic REF_CLK,
    input  wire logic RST_B,
    input  wire logic SCL,
    input  wire logic SDA_IN,
    output logic      SDA_OUT,
    output logic      SDA_OE,
    input  wire logic SELECT_PIN_2,
    input  wire logic SELECT_PIN_1,
    input  wire logic SELECT_PIN_0,
    input  wire logic WRITE_PROTECT,
    output logic      PROGRAM_BUSY
);

    // ========================================================================
    // Pin synchronisers and noise filter
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic [1:0] filt;          // [1] clock, [0] data
    logic [1:0] filt_cnt [2];
    logic       scl_d;
    logic       sda_d;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pin_meta <= PIN_RESET;
            pin_sync <= PIN_RESET;
        end else begin
            pin_meta <= {SCL, SDA_IN, SELECT_PIN_2, SELECT_PIN_1, SELECT_PIN_0, WRITE_PROTECT};
            pin_sync <= pin_meta;
        end
    end

    // A level must differ for FILTER_CYCLES clocks before it is taken
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            filt     <= 2'h3;
            filt_cnt <= '{2'h0, 2'h0};
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (pin_sync[4+i] == filt[i]) begin
                    filt_cnt[i] <= 2'h0;
                end else if (filt_cnt[i] == FILTER_LAST) begin
                    filt[i]     <= pin_sync[4+i];
                    filt_cnt[i] <= 2'h0;
                end else begin
                    filt_cnt[i] <= filt_cnt[i] + 2'h1;
                end
            end
            scl_d <= filt[1];
            sda_d <= filt[0];
        end
    end

    // Edge and condition decode
    wire       scl_f     = filt[1];
    wire       sda_f     = filt[0];
    wire       scl_rise  = scl_f && !scl_d;
    wire       scl_fall  = !scl_f && scl_d;
    wire       start_det = scl_f && scl_d && sda_d && !sda_f;
    wire       stop_det  = scl_f && scl_d && !sda_d && sda_f;
    wire [2:0] sel_s     = pin_sync[3:1];
    wire       wp_s      = pin_sync[0];

    // ========================================================================
    // Protocol state
    state_t                st;
    phase_t                ph;
    logic                  rw;
    logic                  ack_ok;
    logic [3:0]            bit_cnt;
    logic [7:0]            shift;
    logic [7:0]            waddr;
    logic [7:0]            page_data [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_valid;
    logic [7:0]            mem [ARRAY_BYTES];
    logic [PROG_CNT_W-1:0] prog_cnt;
    logic [7:0]            pf_addr;
    logic                  fifo_ready;
    logic                  fifo_valid;
    logic [7:0]            fifo_data;

    wire [7:0] rx_byte   = {shift[6:0], sda_f};
    wire       byte_done = (st == ST_RX) && scl_rise && (bit_cnt == 4'h7);
    wire       dev_match = (rx_byte[7:4] == DEV_TYPE_CODE) && (rx_byte[3:1] == sel_s);
    wire       accept    = byte_done && (ph == PH_DATA) && !rw;
    wire       lock_hit  = is_protected(waddr, wp_s);
    wire       load_tx   = scl_fall && (((st == ST_ACK) && rw && (ph == PH_DEV))
                                        || ((st == ST_MACK) && ack_ok));
    wire       prog_end  = (st == ST_PROG) && (prog_cnt == PROG_CNT_W'(PROGRAM_CYCLES - 1));
    wire       fill_en   = rw && ((st == ST_ACK) || (st == ST_TX) || (st == ST_MACK));

    // Main sequencer: bits in on rise, bits and acknowledge out after fall
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st <= ST_IDLE;
            ph <= PH_DEV;
            rw <= 1'b0;
            ack_ok <= 1'b0;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            waddr <= ADDR_RESET;
            page_valid <= '0;
            prog_cnt <= '0;
            SDA_OE <= 1'b0;
            PROGRAM_BUSY <= 1'b0;
        end else if (st == ST_PROG) begin
            // Pins are ignored until the array update completes
            prog_cnt <= prog_cnt + 1'b1;
            if (prog_end) begin
                st <= ST_IDLE;
                page_valid <= '0;
                PROGRAM_BUSY <= 1'b0;
            end
        end else if (start_det) begin
            st <= ST_RX;
            ph <= PH_DEV;
            rw <= 1'b0;
            bit_cnt <= 4'h0;
            page_valid <= '0;
            SDA_OE <= 1'b0;
        end else if (stop_det) begin
            SDA_OE <= 1'b0;
            prog_cnt <= '0;
            st <= (page_valid != '0) ? ST_PROG : ST_IDLE;
            PROGRAM_BUSY <= (page_valid != '0);
        end else begin
            case (st)
                ST_RX: begin
                    if (scl_rise && bit_cnt != BIT_LAST) begin
                        shift <= rx_byte;
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (byte_done) begin
                        ack_ok <= (ph != PH_DEV) || dev_match;
                        if (ph == PH_DEV) rw <= rx_byte[0];
                        if (ph == PH_WADDR) waddr <= rx_byte;
                        if (accept) begin
                            page_data[waddr[2:0]] <= rx_byte;
                            if (!lock_hit) page_valid[waddr[2:0]] <= 1'b1;
                            waddr[2:0] <= waddr[2:0] + 3'h1;
                        end
                    end
                    if (scl_fall && bit_cnt == BIT_LAST) begin
                        SDA_OE <= ack_ok;
                        st <= ack_ok ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (load_tx) begin
                            shift <= fifo_data;
                            SDA_OE <= !fifo_data[7];
                            ph <= PH_DATA;
                            st <= ST_TX;
                        end else begin
                            SDA_OE <= 1'b0;
                            ph <= (ph == PH_DEV) ? PH_WADDR : PH_DATA;
                            st <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) bit_cnt <= bit_cnt + 4'h1;
                    if (scl_fall) begin
                        if (bit_cnt == BIT_LAST) begin
                            SDA_OE <= 1'b0;
                            st <= ST_MACK;
                        end else begin
                            SDA_OE <= !shift[6];
                            shift <= {shift[6:0], 1'b0};
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) ack_ok <= !sda_f;
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (load_tx) begin
                            shift <= fifo_data;
                            SDA_OE <= !fifo_data[7];
                            st <= ST_TX;
                        end else begin
                            st <= ST_IDLE;
                        end
                    end
                end
                default: st <= ST_IDLE;
            endcase
            // Read address counter rolls over the whole array
            if (load_tx) waddr <= waddr + 8'h01;
        end
    end

    // Open-drain data: only ever pulls low
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) SDA_OUT <= 1'b0;
        else        SDA_OUT <= 1'b0;
    end

    // Array update of only the received, unlocked bytes of the page
    always_ff @(posedge REF_CLK) begin
        if (prog_end) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (page_valid[i]) mem[{waddr[7:3], 3'(i)}] <= page_data[i];
            end
        end
    end

    // ========================================================================
    // Read prefetch: array bytes queue ahead of the serial shifter
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B)                       pf_addr <= ADDR_RESET;
        else if (start_det)               pf_addr <= waddr;
        else if (fill_en && fifo_ready)   pf_addr <= pf_addr + 8'h01;
    end

    byte_fifo2 #(.WIDTH(8), .DEPTH(2)) u_prefetch (
        .clk       (REF_CLK),
        .rst_b     (RST_B),
        .clear     (start_det),
        .in_valid  (fill_en),
        .in_ready  (fifo_ready),
        .in_data   (mem[pf_addr]),
        .out_valid (fifo_valid),
        .out_ready (load_tx),
        .out_data  (fifo_data)
    );

    // ========================================================================
    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    sequence s_start_seen;
        start_det && (st != ST_PROG);
    endsequence

    sequence s_ack_begin;
        (st == ST_RX) && (bit_cnt == BIT_LAST) && scl_fall && ack_ok;
    endsequence

    AST_SAMPLE_RISE: assert property ((st == ST_RX) && scl_rise && (bit_cnt < BIT_LAST)
        |=> (shift[0] == $past(sda_f)) && (bit_cnt == $past(bit_cnt) + 4'h1))
        else $error("Data bit not sampled on clock rise");
    AST_DRIVE_FALL: assert property ($changed(SDA_OE) |-> $past(scl_fall || start_det || stop_det))
        else $error("Data output changed away from a clock fall");
    AST_OPEN_DRAIN: assert property (SDA_OE |-> !SDA_OUT)
        else $error("Data pin driven high");
    AST_SELECT_MISS: assert property (byte_done && (ph == PH_DEV) && !dev_match
        |=> !ack_ok ##[1:40] (st == ST_IDLE) && !SDA_OE)
        else $error("Unmatched device byte did not return to standby");
    AST_START: assert property (s_start_seen |=> (st == ST_RX) && (bit_cnt == 4'h0) && !SDA_OE)
        else $error("Start not taken");
    AST_ACK: assert property (s_ack_begin |=> SDA_OE && (st == ST_ACK))
        else $error("Received byte not acknowledged");
    AST_PROTECT: assert property (accept && lock_hit |=> $stable(page_valid))
        else $error("Locked location queued for update");
    AST_PAGE_WRAP: assert property (accept |=> (waddr[7:3] == $past(waddr[7:3]))
        && (waddr[2:0] == $past(waddr[2:0]) + 3'h1))
        else $error("Page address did not wrap within page");
    AST_PROG_BOUND: assert property ((st == ST_PROG) |-> (prog_cnt < PROG_CNT_W'(PROGRAM_CYCLES)))
        else $error("Programming overran its time");
    AST_PROG_END: assert property (prog_end |=> (st == ST_IDLE) && !PROGRAM_BUSY && (page_valid == '0))
        else $error("Programming did not finish cleanly");
    AST_FIFO_READY: assert property (load_tx |-> fifo_valid)
        else $error("Read byte not ready when needed");

endmodule : two_wire_eeprom_target
`default_nettype wire

// >>> test/two_wire_controller_model.sv
// Behavioural two-wire bus controller: makes the serial clock, pulls data low.
// Assumes an outside pull-up; the clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module two_wire_controller_model (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // Quarter of a 320 ns serial clock period. The low phase must outlast the
    // target's pin-to-output latency, or its own data change under a high clock
    // would look like a start or stop.
    localparam int Q = 80;

    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // ========================================================================
    // Conditions: data moves under a high clock only here
    task automatic start_cond();
        #7;
        sda_pull = 1'b0;
        #(4*Q);
        scl = 1'b1;
        #(2*Q);
        sda_pull = 1'b1;
        #(2*Q);
        scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        #(Q);
        sda_pull = 1'b1;
        #(Q);
        scl = 1'b1;
        #(2*Q);
        sda_pull = 1'b0;
        #(2*Q);
    endtask : stop_cond

    // ========================================================================
    // One bit: data set in the low phase, wire sampled late in the high phase
    task automatic put_bit(input logic b, output logic seen);
        #(Q);
        sda_pull = ~b; // Only pulls low or releases
        #(Q);
        scl = 1'b1;
        #(2*Q - 1);
        seen = sda;
        #1;
        scl = 1'b0;
    endtask : put_bit

    // Byte out, most significant bit first, then the ninth clock
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(d[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask : write_byte

    task automatic read_byte(input logic give_ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
        put_bit(~give_ack, s);
    endtask : read_byte
endmodule : two_wire_controller_model
`default_nettype wire

// >>> test/test_two_wire_eeprom_target.sv
// Self-checking bench for the two-wire serial memory target.
// Assumes the controller model beside it; the data wire has a pull-up.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module test_two_wire_eeprom_target
    import eeprom_pkg::*;
;
    localparam int PROG = 400; // Shortened self-timed write, longer than one poll
    logic       REF_CLK, RST_B, WRITE_PROTECT, SDA_OUT, SDA_OE, PROGRAM_BUSY, scl, pull;
    logic [2:0] pins;
    logic [7:0] exp_mem [256];
    bit         known [256];
    int         num_errors = 0;
    int         tests_run  = 0;
    wire        sda = ~(pull | SDA_OE); // Open-drain wire with pull-up

    two_wire_eeprom_target #(.PROGRAM_CYCLES(PROG)) uut (
        .REF_CLK(REF_CLK), .RST_B(RST_B), .SCL(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT),
        .SDA_OE(SDA_OE), .SELECT_PIN_2(pins[2]), .SELECT_PIN_1(pins[1]),
        .SELECT_PIN_0(pins[0]), .WRITE_PROTECT(WRITE_PROTECT), .PROGRAM_BUSY(PROGRAM_BUSY));
    two_wire_controller_model ctl (.scl(scl), .sda_pull(pull), .sda(sda));

    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end

    // Drive value never high on the open-drain pin
    always @(posedge REF_CLK) `CHECK(SDA_OUT, 1'b0)

    // ========================================================================
    // Shared tasks
    task automatic end_of_test();
        $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    task automatic address(input logic rw, input logic [2:0] sel, output logic ack);
        ctl.start_cond();
        ctl.write_byte({DEV_TYPE_CODE, sel, rw}, ack);
    endtask : address

    // Stop, then time the busy phase while polling for an acknowledge
    task automatic commit(input logic prog_due);
        int n;
        logic ack;
        time t0;
        n = 0;
        t0 = 0;
        if (!prog_due) begin
            ctl.stop_cond();
            repeat (PROG + 40) @(posedge REF_CLK);
            return;
        end
        // Watch for busy while the stop is still being driven
        fork
            ctl.stop_cond();
            begin
                while (PROGRAM_BUSY !== 1'b1 && n < 60) begin @(posedge REF_CLK); #1; n++; end
                t0 = $time;
            end
        join
        `CHECK(PROGRAM_BUSY, 1'b1)
        if (PROGRAM_BUSY !== 1'b1) end_of_test();
        n = 0;
        fork
            while (PROGRAM_BUSY === 1'b1 && n < PROG + 20) begin
                @(posedge REF_CLK);
                #1;
                n++;
            end
            begin address(1'b0, pins, ack); ctl.stop_cond(); `CHECK(ack, 1'b0) end
        join
        `CHECK(int'(($time - t0) / 20), PROG)
        if (n >= PROG + 20) end_of_test();
    endtask : commit

    task automatic write_bytes(input logic [7:0] addr, input logic [7:0] data [$]);
        logic ack;
        logic wrote;
        logic [7:0] a;
        a = addr;
        wrote = 1'b0;
        address(1'b0, pins, ack);
        `CHECK(ack, 1'b1)
        ctl.write_byte(addr, ack);
        `CHECK(ack, 1'b1)
        foreach (data[i]) begin
            ctl.write_byte(data[i], ack);
            `CHECK(ack, 1'b1)
            if (!(WRITE_PROTECT && a[7])) begin // Locked half keeps old data
                exp_mem[a] = data[i];
                known[a] = 1'b1;
                wrote = 1'b1;
            end
            a = {a[7:3], a[2:0] + 3'h1}; // Wrap inside the page
        end
        commit(wrote);
    endtask : write_bytes

    task automatic read_check(input logic [7:0] addr, input int n);
        logic ack;
        logic [7:0] a;
        logic [7:0] d;
        a = addr;
        address(1'b0, pins, ack);
        ctl.write_byte(addr, ack);
        `CHECK(ack, 1'b1)
        address(1'b1, pins, ack);
        `CHECK(ack, 1'b1)
        for (int i = 0; i < n; i++) begin
            ctl.read_byte(i < n - 1, d);
            if (known[a]) `CHECK(d, exp_mem[a])
            a = a + 8'h01;
        end
        ctl.stop_cond();
        repeat (10) @(posedge REF_CLK);
    endtask : read_check

    // ========================================================================
    // Scenarios
    task automatic t_glitch();
        logic ack;
        @(posedge REF_CLK);
        #5;
        ctl.sda_pull = 1'b1; // Two-cycle dip under a high clock
        #40;
        ctl.sda_pull = 1'b0;
        #200;
        ctl.scl = 1'b0;
        ctl.write_byte({DEV_TYPE_CODE, pins, 1'b1}, ack);
        ctl.stop_cond();
        `CHECK(ack, 1'b0)
        $display("glitch test done");
    endtask : t_glitch

    task automatic t_select();
        logic ack;
        logic [7:0] d;
        for (int k = 0; k < 8; k++) begin
            @(posedge REF_CLK);
            pins <= 3'(k);
            repeat (4) @(posedge REF_CLK);
            address(1'b1, 3'(k) ^ (3'h1 << (k % 3)), ack);
            ctl.stop_cond();
            `CHECK(ack, 1'b0)
            address(1'b1, 3'(k), ack);
            `CHECK(ack, 1'b1)
            ctl.read_byte(1'b0, d);
            ctl.stop_cond();
        end
        ctl.start_cond();
        ctl.write_byte({4'hB, pins, 1'b1}, ack);
        ctl.stop_cond();
        `CHECK(ack, 1'b0)
        $display("select test done");
    endtask : t_select

    task automatic t_page();
        write_bytes(8'h10, '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8});
        write_bytes(8'h16, '{8'hC6, 8'hC7, 8'hC0});
        write_bytes(8'hFF, '{8'h5A});
        write_bytes(8'h00, '{8'hA5});
        read_check(8'h10, 8);
        read_check(8'hFF, 2);
        $display("page test done");
    endtask : t_page

    task automatic t_protect();
        write_bytes(8'h7F, '{8'h11});
        write_bytes(8'h80, '{8'h22});
        @(posedge REF_CLK);
        WRITE_PROTECT <= 1'b1;
        write_bytes(8'h7F, '{8'h33});
        write_bytes(8'h80, '{8'h44});
        read_check(8'h7F, 2);
        @(posedge REF_CLK);
        WRITE_PROTECT <= 1'b0;
        $display("protect test done");
    endtask : t_protect

    initial begin
        RST_B = 1'b0;
        WRITE_PROTECT = 1'b0;
        pins = 3'h5;
        repeat (6) @(posedge REF_CLK);
        RST_B <= 1'b1;
        repeat (10) @(posedge REF_CLK);
        #1;
        `CHECK(PROGRAM_BUSY, 1'b0)
        `CHECK(SDA_OE, 1'b0)
        t_glitch();
        t_select();
        t_page();
        t_protect();
        end_of_test();
    end
endmodule : test_two_wire_eeprom_target
`default_nettype wire
